// *** msi_inputs.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Each input evaluated alone; resulting actions combine by OR.
// - Debounce delay configurable from 10 ms to 80 ms, one setting shared by both inputs.
// - Polarity bit selects normally open or normally closed contact.
// - Emergency start and run actions allow only normally open.
// - Input-switch-off bit follows any active switch-off action input.
// - Reported input levels are always normally-open levels.
// - Signal bit selects latching (stored) or inching (not stored).
// - Latched run without switch-off or quick-stop rejects parameters.
// - Trip without restart: inching only, needs ack after cause clears.
// - Trip with restart switches off; auto-acknowledged after cause clears.
// - End-position switch-off turns motor and brake off, any direction.
// - Brake re-enabled only after brake and run commands cleared.
// - After end switch-off only the opposite run command restarts.
// - General warning sets warning, motor and brake stay on.
// - Latched warning triggers on active edge; cleared by trip reset.
// - Manual mode: only input run actions control motor, bus ignored.
// - Automatic returns only when manual cancelled and no input run.
// - Inching: action active while input at its active level.
module msi_inputs #(
  parameter int STEP_CYC = msi_pkg::MSI_STEP_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] din_i,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic motor_cw_o,
  output logic motor_ccw_o,
  output logic brake_o,
  output logic warn_o
);
  import msi_pkg::*;

  initial begin
    if (STEP_CYC < 1) $error("STEP_CYC must be positive");
  end

  localparam int CW = $clog2(STEP_CYC * 8 + 1);

  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [3:0] cmd_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic parerr_r;
  logic trip_r;
  logic warn_r;
  logic swoff_r;
  logic endcw_r;
  logic endccw_r;
  logic brake_lock_r;
  logic manual_r;
  logic mcw_r;
  logic mccw_r;
  logic brk_r;
  logic [1:0] lvl_r;
  logic [1:0] lvl_d_r;
  logic [1:0] lat_r;
  logic [31:0] stat;
  logic [31:0] rdata_nxt;

  // Bus: answer one cycle after request
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  wire acc = req & ack_r;
  wire wr_cfg = acc & avs_write & (avs_address == MSI_REG_CFG);
  wire wr_cmd = acc & avs_write & (avs_address == MSI_REG_CMD);

  function automatic logic is_run(input logic [3:0] a);
    return a == MSI_ACT_RUN_CW || a == MSI_ACT_RUN_CCW;
  endfunction
  function automatic logic is_stop(input logic [3:0] a);
    return a == MSI_ACT_SWOFF || a == MSI_ACT_QSTOP;
  endfunction
  function automatic logic no_only(input logic [3:0] a);
    return is_run(a) || a == MSI_ACT_EMERG;
  endfunction

  wire [3:0] act0_w = avs_writedata[MSI_CFG_ACT0_LSB +: 4];
  wire [3:0] act1_w = avs_writedata[MSI_CFG_ACT1_LSB +: 4];
  wire [1:0] nc_w = avs_writedata[MSI_CFG_NC_LSB +: 2];
  wire [1:0] la_w = avs_writedata[MSI_CFG_LATCH_LSB +: 2];
  wire [2:0] dly_w = avs_writedata[MSI_CFG_DLY_LSB +: 3];
  // Parameter set consistency check
  wire bad_pol = (no_only(act0_w) & nc_w[0]) |
    (no_only(act1_w) & nc_w[1]);
  wire bad_la = ((la_w[0] & is_run(act0_w)) |
    (la_w[1] & is_run(act1_w))) &
    ~(is_stop(act0_w) | is_stop(act1_w));
  wire bad_trip = (la_w[0] & act0_w == MSI_ACT_TRIP_NORST) |
    (la_w[1] & act1_w == MSI_ACT_TRIP_NORST);
  wire bad_cfg = bad_pol | bad_la | bad_trip;
  assign cfg_nxt = (wr_cfg & ~bad_cfg) ? avs_writedata : cfg_r;

  wire [3:0] act0 = cfg_r[MSI_CFG_ACT0_LSB +: 4];
  wire [3:0] act1 = cfg_r[MSI_CFG_ACT1_LSB +: 4];
  wire [1:0] nc = cfg_r[MSI_CFG_NC_LSB +: 2];
  wire [1:0] la = cfg_r[MSI_CFG_LATCH_LSB +: 2];
  wire [CW-1:0] dly_cyc = CW'((cfg_r[MSI_CFG_DLY_LSB +: 3] + 4'h1) *
    STEP_CYC);

  // Per-input synchroniser, debounce and active level
  logic [1:0] act_lvl;
  logic [1:0] raw_act;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gin
      logic [2:0] sy_r;
      logic [CW-1:0] cnt_r;
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          sy_r <= 3'h0;
        end else begin
          sy_r <= {sy_r[1:0], din_i[g]};
        end
      end
      wire stable = sy_r[2] == sy_r[1];
      wire diff = stable & (sy_r[2] != lvl_r[g]);
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          cnt_r <= '0;
          lvl_r[g] <= 1'b0;
        end else if (!diff) begin
          cnt_r <= '0;
        end else if (cnt_r >= dly_cyc - CW'(1)) begin
          cnt_r <= '0;
          lvl_r[g] <= sy_r[2];
        end else begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
      // NC contact is active when open
      assign raw_act[g] = lvl_r[g] ^ nc[g];
      // Direct polarity view: current debounced state decides act level
      assign act_lvl[g] = raw_act[g];
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lvl_d_r <= 2'h0;
    end else begin
      lvl_d_r <= act_lvl;
    end
  end
  wire [1:0] rise = act_lvl & ~lvl_d_r;

  // Action decode per input, then OR across inputs
  function automatic logic hit(input logic [3:0] a0, input logic [3:0] a1,
                               input logic [1:0] on, input logic [3:0] k);
    return (on[0] & a0 == k) | (on[1] & a1 == k);
  endfunction
  wire [1:0] eff = act_lvl | lat_r;
  wire trip_norst = hit(act0, act1, act_lvl, MSI_ACT_TRIP_NORST);
  wire trip_rst = hit(act0, act1, act_lvl, MSI_ACT_TRIP_RST);
  wire end_cw = hit(act0, act1, act_lvl, MSI_ACT_END_CW);
  wire end_ccw = hit(act0, act1, act_lvl, MSI_ACT_END_CCW);
  wire manual_in = hit(act0, act1, act_lvl, MSI_ACT_MANUAL);
  wire emerg = hit(act0, act1, act_lvl, MSI_ACT_EMERG);
  wire in_cw = hit(act0, act1, eff, MSI_ACT_RUN_CW);
  wire in_ccw = hit(act0, act1, eff, MSI_ACT_RUN_CCW);
  wire swoff = hit(act0, act1, act_lvl, MSI_ACT_SWOFF);
  wire qstop = hit(act0, act1, eff, MSI_ACT_QSTOP);
  wire warn_now = hit(act0, act1, act_lvl & ~la, MSI_ACT_WARN);
  wire warn_set = hit(act0, act1, rise & la, MSI_ACT_WARN);
  wire ack = wr_cmd & avs_writedata[MSI_CMD_ACK];

  // Manual mode ends only once no input run action remains
  wire manual_nxt = manual_in | (manual_r & (in_cw | in_ccw));
  wire cmd_cw = manual_r ? in_cw : cmd_r[MSI_CMD_CW];
  wire cmd_ccw = manual_r ? in_ccw : cmd_r[MSI_CMD_CCW];
  wire cmd_brk = manual_r ? (in_cw | in_ccw) : cmd_r[MSI_CMD_BRAKE];
  // Autoreset trips do not latch; only trip-without-restart holds
  wire hold_on = emerg;
  wire stop = ((trip_r | trip_norst | trip_rst | swoff | qstop) & ~hold_on)
    | end_cw | end_ccw;
  wire run_cw = cmd_cw & ~cmd_ccw & ~stop & ~endcw_r;
  wire run_ccw = cmd_ccw & ~cmd_cw & ~stop & ~endccw_r;
  wire brk_clear = ~cmd_brk & ~cmd_cw & ~cmd_ccw;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cfg_r <= MSI_CFG_RESET;
      cmd_r <= 4'h0;
      ack_r <= 1'b0;
      parerr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      ack_r <= req & ~ack_r;
      if (wr_cmd) begin
        cmd_r <= avs_writedata[3:0];
      end
      if (wr_cfg) begin
        parerr_r <= bad_cfg;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      trip_r <= 1'b0;
      warn_r <= 1'b0;
      manual_r <= 1'b0;
      lat_r <= 2'h0;
    end else begin
      trip_r <= trip_norst | (trip_r & ~ack);
      warn_r <= warn_set | (warn_r & ~ack);
      manual_r <= manual_nxt;
      // Latched actions stored; ack clears, a new edge in that cycle wins
      lat_r <= (lat_r & ~{2{ack}}) | (rise & la);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      endcw_r <= 1'b0;
      endccw_r <= 1'b0;
      brake_lock_r <= 1'b0;
      swoff_r <= 1'b0;
    end else begin
      endcw_r <= end_cw | (endcw_r & ~cmd_ccw);
      endccw_r <= end_ccw | (endccw_r & ~cmd_cw);
      brake_lock_r <= end_cw | end_ccw |
        (brake_lock_r & ~brk_clear);
      swoff_r <= swoff;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mcw_r <= 1'b0;
      mccw_r <= 1'b0;
      brk_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      mcw_r <= run_cw;
      mccw_r <= run_ccw;
      brk_r <= cmd_brk & ~stop & ~brake_lock_r;
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    stat = 32'h0;
    stat[MSI_ST_MOTOR_CW] = mcw_r;
    stat[MSI_ST_MOTOR_CCW] = mccw_r;
    stat[MSI_ST_BRAKE] = brk_r;
    stat[MSI_ST_TRIP] = trip_r;
    stat[MSI_ST_WARN] = warn_o;
    stat[MSI_ST_MANUAL] = manual_r;
    stat[MSI_ST_PARERR] = parerr_r;
    stat[MSI_ST_INSWOFF] = swoff_r;
    stat[MSI_ST_ENDCW] = endcw_r;
    stat[MSI_ST_ENDCCW] = endccw_r;
  end
  // Levels reported as make-contact regardless of polarity
  wire [31:0] lvl_rep = {30'h0, lvl_r};
  assign rdata_nxt =
    (avs_address == MSI_REG_CFG) ? cfg_r :
    (avs_address == MSI_REG_CMD) ? {28'h0, cmd_r} :
    (avs_address == MSI_REG_STAT) ? stat :
    (avs_address == MSI_REG_LVL) ? lvl_rep : 32'h0;

  assign avs_readdata = rdata_r;
  assign motor_cw_o = mcw_r;
  assign motor_ccw_o = mccw_r;
  assign brake_o = brk_r;
  assign warn_o = warn_r | warn_now;

  end_stop_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (end_cw | end_ccw) |=> !motor_cw_o && !motor_ccw_o && !brake_o)
    else $error("motor on during end switch-off");
  end_dir_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    endcw_r |=> !motor_cw_o)
    else $error("cw restart after cw end");
  trip_off_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (trip_norst | trip_rst) && !emerg |=> !motor_cw_o && !brake_o)
    else $error("motor on during trip");
  trip_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    trip_r && !ack |=> trip_r)
    else $error("trip cleared without ack");
  warn_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    warn_set |=> warn_o)
    else $error("latched warning lost");
  manual_bus_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    manual_r && !in_cw |=> !motor_cw_o)
    else $error("bus drove motor in manual");
  pol_ok_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !(no_only(act0) && nc[0]))
    else $error("run action with nc contact");
  lvl_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $changed(lvl_r[0]) |-> $past(gin[0].sy_r[2]) == lvl_r[0])
    else $error("level taken unsynchronised");
  bus_wait_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not in one cycle");
  run_c: cover property (@(posedge mclk_i) motor_cw_o);
  manual_c: cover property (@(posedge mclk_i) manual_r && motor_ccw_o);
  endsw_c: cover property (@(posedge mclk_i) endcw_r ##1 motor_ccw_o);
endmodule
`default_nettype wire

// *** msi_pkg.sv ***
package msi_pkg;
  // Input actions
  typedef enum logic [3:0] {
    MSI_ACT_NONE,
    MSI_ACT_TRIP_NORST,
    MSI_ACT_TRIP_RST,
    MSI_ACT_END_CW,
    MSI_ACT_END_CCW,
    MSI_ACT_WARN,
    MSI_ACT_MANUAL,
    MSI_ACT_EMERG,
    MSI_ACT_RUN_CW,
    MSI_ACT_RUN_CCW,
    MSI_ACT_SWOFF,
    MSI_ACT_QSTOP
  } msi_act_e;

  // Register byte offsets
  localparam logic [3:0] MSI_REG_CFG = 4'h0;
  localparam logic [3:0] MSI_REG_CMD = 4'h4;
  localparam logic [3:0] MSI_REG_STAT = 4'h8;
  localparam logic [3:0] MSI_REG_LVL = 4'hC;

  // CFG fields
  localparam int MSI_CFG_ACT0_LSB = 0;
  localparam int MSI_CFG_ACT1_LSB = 4;
  localparam int MSI_CFG_NC_LSB = 8;
  localparam int MSI_CFG_LATCH_LSB = 10;
  localparam int MSI_CFG_DLY_LSB = 12;
  // CMD fields
  localparam int MSI_CMD_CW = 0;
  localparam int MSI_CMD_CCW = 1;
  localparam int MSI_CMD_BRAKE = 2;
  localparam int MSI_CMD_ACK = 3;
  // STAT fields
  localparam int MSI_ST_MOTOR_CW = 0;
  localparam int MSI_ST_MOTOR_CCW = 1;
  localparam int MSI_ST_BRAKE = 2;
  localparam int MSI_ST_TRIP = 3;
  localparam int MSI_ST_WARN = 4;
  localparam int MSI_ST_MANUAL = 5;
  localparam int MSI_ST_PARERR = 6;
  localparam int MSI_ST_INSWOFF = 7;
  localparam int MSI_ST_ENDCW = 8;
  localparam int MSI_ST_ENDCCW = 9;

  localparam logic [31:0] MSI_CFG_RESET = 32'h0000_0000;
  // Debounce timing
  localparam int MSI_CLK_HZ = 40_000_000;
  localparam int MSI_DLY_STEP_MS = 10;
  localparam int MSI_DLY_MAX_MS = 80;
  localparam int MSI_STEP_CYC = MSI_CLK_HZ / 1000 * MSI_DLY_STEP_MS;
endpackage

// *** msi_contacts.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two PNP contacts; each change chatters a few cycles
// Chatter is shorter than the debounce time used on the bench
module msi_contacts (
  input wire logic mclk_i,
  input wire logic [1:0] close_i,
  output logic [1:0] din_o
);
  logic [1:0] prev_r = 2'h0;
  logic [1:0] ch_r = 2'h0;
  logic [1:0] d_r = 2'h0;
  assign din_o = d_r;
  always @(posedge mclk_i) begin
    prev_r <= close_i;
    if (close_i != prev_r) begin
      ch_r <= 2'h3;
    end else if (ch_r != 2'h0) begin
      ch_r <= ch_r - 2'h1;
    end
    d_r <= (ch_r != 2'h0) ? ~d_r : close_i;
  end
endmodule
`default_nettype wire

// *** msi_inputs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module msi_inputs_tb_top;
  import msi_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] close = 2'h0;
  logic [1:0] din;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cw, ccw, brk, warn;
  logic [3:0] outs;
  logic [31:0] q;
  logic [25:0] rows [8];
  int fails = 0;
  int checks_done = 0;
  assign outs = {cw, ccw, brk, warn};
  always #12.5 mclk_i = ~mclk_i;
  msi_contacts PM (.mclk_i(mclk_i), .close_i(close), .din_o(din));
  msi_inputs #(.STEP_CYC(4)) DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .din_i(din),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .motor_cw_o(cw), .motor_ccw_o(ccw), .brake_o(brk), .warn_o(warn)
  );
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Held until waitrequest is seen low, released after that edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      fails++;
      final_report();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Long enough for chatter, sync and the longest bench delay
  task automatic setin(input logic [1:0] d);
    @(posedge mclk_i);
    close <= d;
    repeat (40) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic cmd(input logic [3:0] m);
    bus(1'b1, MSI_REG_CMD, {28'h0, m});
    setin(close);
  endtask
  task automatic step(input logic [15:0] c, input logic [1:0] d,
                      input logic [3:0] m);
    bus(1'b1, MSI_REG_CFG, {16'h0, c});
    setin(d);
    cmd(m);
  endtask
  task automatic clr;
    step(16'h0000, 2'h0, 4'h0);
    cmd(4'h8);
  endtask
  initial begin
    rows = '{
      {16'h0000, 2'h0, 4'h5, 4'hA},
      {16'h0002, 2'h1, 4'h5, 4'h0},
      {16'h0005, 2'h1, 4'h5, 4'hB},
      {16'h0250, 2'h0, 4'h5, 4'hB},
      {16'h00A0, 2'h2, 4'h5, 4'h0},
      {16'h0052, 2'h2, 4'h5, 4'hB},
      {16'h0004, 2'h1, 4'h6, 4'h0},
      {16'h0030, 2'h2, 4'h5, 4'h0}};
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    chk(outs, 32'h0);
    rdc(MSI_REG_CFG, MSI_CFG_RESET);
    rdc(4'h1, 32'h0);
    $display("reset done");
    for (int i = 0; i < 8; i++) begin
      clr();
      step(rows[i][25:10], rows[i][9:8], rows[i][7:4]);
      chk(outs, rows[i][3:0]);
      rdc(MSI_REG_LVL, rows[i][9:8]);
    end
    $display("table done");
    // End switch-off clockwise still locked from the last row
    setin(2'h0);
    cmd(4'h1);
    chk(cw, 1'b0);
    cmd(4'h0);
    cmd(4'h2);
    chk(ccw, 1'b1);
    $display("end lock done");
    clr();
    step(16'h0086, 2'h1, 4'h1);
    chk(cw, 1'b0);
    setin(2'h3);
    chk(cw, 1'b1);
    setin(2'h0);
    cmd(4'h1);
    chk(cw, 1'b1);
    $display("manual done");
    clr();
    step(16'h0001, 2'h1, 4'h5);
    chk(outs, 32'h0);
    setin(2'h0);
    chk(outs, 32'h0);
    cmd(4'hD);
    chk(outs, 32'hA);
    $display("trip done");
    clr();
    step(16'h0405, 2'h1, 4'h5);
    chk(warn, 1'b1);
    setin(2'h0);
    chk(warn, 1'b1);
    cmd(4'hD);
    chk(warn, 1'b0);
    $display("latch done");
    clr();
    step(16'h1002, 2'h0, 4'h5);
    @(posedge mclk_i);
    close <= 2'h1;
    repeat (5) @(posedge mclk_i);
    setin(2'h0);
    chk(outs, 32'hA);
    setin(2'h1);
    chk(outs, 32'h0);
    $display("debounce done");
    clr();
    step(16'h00A0, 2'h2, 4'h0);
    bus(1'b0, MSI_REG_STAT, 32'h0);
    chk(q[MSI_ST_INSWOFF], 1'b1);
    $display("switch-off done");
    clr();
    bus(1'b1, MSI_REG_CFG, 32'h0108);
    bus(1'b0, MSI_REG_STAT, 32'h0);
    chk(q[MSI_ST_PARERR], 1'b1);
    rdc(MSI_REG_CFG, 32'h0);
    bus(1'b1, MSI_REG_CFG, 32'h0408);
    bus(1'b0, MSI_REG_STAT, 32'h0);
    chk(q[MSI_ST_PARERR], 1'b1);
    bus(1'b1, MSI_REG_CFG, 32'h04A8);
    bus(1'b0, MSI_REG_STAT, 32'h0);
    chk(q[MSI_ST_PARERR], 1'b0);
    rdc(MSI_REG_CFG, 32'h04A8);
    $display("params done");
    final_report();
  end
endmodule
`default_nettype wire
